/* design/aops_seq.sv */
// How it works
// - pacing derives from a 48 MHz reference made from the clock.
// - sample rate is programmed by divider, 30 kHz to 216 kHz.
// - output rate is set alone; no tie to the input side.
// - after start, 36 ticks of group delay before conversions count.
// - single value goes straight to the chosen channel.
// - single value ends by itself; nothing can stop it.
// - waveform loaded whole into FIFO, then played on software start.
// - waveform read pointer wraps to first slot, forever until stop.
// - mute ramps output to zero over 1020 samples; unmute restores.
// - continuous mode plays queued data after a trigger until done.
// - continuous mode ends when no more data is queued.
// - converter wanting data with empty queue flags underrun.
// - orderly stop plays the asked count, halts, ignores triggers.
// - abrupt stop halts at once and ignores later triggers.
// - start by software or chosen edge on the trigger pin.
// - slave mode takes tick and trigger from the sync bus only.
// - a common start input launches output with the input side.
// - amber led blinks while continuous streaming runs, until an orderly stop starts draining.
// - one or two output channels by parameter.
//
// Implementation choices: the address map and the Avalon-MM slave port.
`default_nettype none
module aops_seq
    import aops_pkg::*;
#(
    parameter int CHANNELS = 2,
    parameter int DEPTH    = aops_pkg::AOPS_FIFO_DEPTH,
    parameter int LED_HALF = aops_pkg::AOPS_LED_HALF
)
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // trigger sources
    input  wire logic        ext_trig,
    input  wire logic        sync_clk,
    input  wire logic        sync_trig,
    input  wire logic        common_start,
    // converter side
    output logic [31:0]      dac0_data,
    output logic [31:0]      dac1_data,
    output logic             dac_strobe,
    // status
    output logic             underrun_evt,
    output logic             led_amber
);
    localparam int AW = $clog2(DEPTH);
    if (CHANNELS < 1 || CHANNELS > 2 || DEPTH < 4 || LED_HALF < 2)
    begin : g_bad_param
        $error("aops_seq: unsupported parameters");
    end
    // control registers
    logic [31:0]  ctrl_r;
    logic [15:0]  div_r;
    logic [AW:0]  len_r;
    logic [31:0]  stopcnt_r;
    logic [31:0]  fifo_mem [DEPTH];
    logic [AW:0]  wp_r;
    logic [AW:0]  rp_r;
    logic [AW:0]  lvl_r;
    aops_state_t  st_r;
    logic [5:0]   dly_r;
    logic [10:0]  ramp_r;
    logic [31:0]  left_r;
    logic         err_r;
    logic         ack_r;
    logic [31:0]  cur0_r;
    logic [31:0]  cur1_r;
    logic         ch_r;
    logic [15:0]  led_cnt_r;
    // decode and bus strobes
    wire bus_req  = (avs_read || avs_write) && avs_waitrequest;
    wire wr       = avs_write && !ack_r;
    wire wr_ctrl  = wr && avs_address == AOPS_REG_CTRL;
    wire wr_cmd   = wr && avs_address == AOPS_REG_CMD;
    wire wr_div   = wr && avs_address == AOPS_REG_DIV;
    wire wr_len   = wr && avs_address == AOPS_REG_LEN;
    wire wr_stop  = wr && avs_address == AOPS_REG_STOPCNT;
    wire wr_sval  = wr && avs_address == AOPS_REG_SVAL;
    wire wr_fifo  = wr && avs_address == AOPS_REG_FIFO;
    wire         wrap_one_buffer_flag = ctrl_r[AOPS_CTRL_WRAP];
    wire         two_ch   = ctrl_r[AOPS_CTRL_TWO] && CHANNELS == 2;
    wire         slave    = ctrl_r[AOPS_CTRL_SLAVE];
    wire         muted    = ctrl_r[AOPS_CTRL_MUTE];
    wire c_start  = wr_cmd && avs_writedata[AOPS_CMD_START];
    wire c_order  = wr_cmd && avs_writedata[AOPS_CMD_ORDER];
    wire c_abort  = wr_cmd && avs_writedata[AOPS_CMD_ABORT];
    wire c_sval   = wr_cmd && avs_writedata[AOPS_CMD_SVAL];
    wire c_clrerr = wr_cmd && avs_writedata[AOPS_CMD_CLRERR];
    wire c_rearm  = wr_cmd && avs_writedata[AOPS_CMD_REARM];
    // trigger selection
    logic ext_hit;
    logic sync_hit;
    logic sclk_hit;
    aops_edge u_ext (.clk(clk), .sys_rst(sys_rst), .pin(ext_trig),
        .neg(ctrl_r[AOPS_CTRL_TNEG]), .hit(ext_hit));
    aops_edge u_strg (.clk(clk), .sys_rst(sys_rst), .pin(sync_trig),
        .neg(1'b0), .hit(sync_hit));
    aops_edge u_sclk (.clk(clk), .sys_rst(sys_rst), .pin(sync_clk),
        .neg(1'b0), .hit(sclk_hit));
    // waveform takes software or common start, not the pin; slave ignores the rest
    wire trig = slave ? sync_hit
        : (c_start || common_start
           || (ctrl_r[AOPS_CTRL_TSRC] && !wrap_one_buffer_flag
               && ext_hit));
    // pacing
    aops_pace_if pace ();
    aops_pacer u_pace (.clk(clk), .sys_rst(sys_rst), .pi(pace));
    wire active = st_r == AOPS_SETTL || st_r == AOPS_RUN
                || st_r == AOPS_DRAIN;
    assign pace.run = active && !slave;
    assign pace.div = div_r;
    wire tick  = active && (slave ? sclk_hit : pace.tick);
    // fifo
    wire [AW:0] need   = two_ch ? (AW+1)'(2) : (AW+1)'(1);
    wire        have   = lvl_r >= need;
    wire        play   = tick && st_r != AOPS_SETTL;
    wire        take   = play && (have || wrap_one_buffer_flag);
    wire        full   = lvl_r == (AW+1)'(DEPTH);
    wire        push   = wr_fifo && !full;
    wire [AW:0] pop_n  = take && !wrap_one_buffer_flag ? need : '0;
    wire [AW:0] rp_a   = rp_r + need;
    wire [AW:0] rp_inc = (wrap_one_buffer_flag && rp_a >= len_r) ? '0
                       : (rp_a == (AW+1)'(DEPTH) ? '0 : rp_a);
    wire [AW:0] rp_1   = (rp_r + 1'b1 == (AW+1)'(DEPTH)) ? '0
                       : rp_r + 1'b1;
    wire [31:0] smp0   = fifo_mem[rp_r[AW-1:0]];
    wire [31:0] smp1   = fifo_mem[rp_1[AW-1:0]];
    // offset-binary ramp toward mid code, which is 0 V
    function automatic logic [31:0] scale(input logic [31:0] s,
                                          input logic [10:0] k);
        logic signed [32:0] d;
        logic signed [44:0] p;
        d = $signed({1'b0, s}) - $signed({1'b0, AOPS_MID});
        p = d * $signed({1'b0, 11'(AOPS_MUTE_STEPS) - k});
        scale = 32'(p / AOPS_MUTE_STEPS + $signed({1'b0, AOPS_MID}));
    endfunction
    always_ff @(posedge clk)
    begin
        if (push)
            fifo_mem[wp_r[AW-1:0]] <= avs_writedata;
    end
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl_r    <= AOPS_CTRL_RST;
            div_r     <= AOPS_DIV_RST;
            len_r     <= '0;
            stopcnt_r <= 32'h0000_0000;
            ack_r     <= 1'b0;
            wp_r      <= '0;
            lvl_r     <= '0;
            err_r     <= 1'b0;
        end
        else
        begin
            ack_r <= bus_req;
            if (wr_ctrl)
                ctrl_r <= avs_writedata;
            if (wr_div && avs_writedata[15:0] >= 16'(AOPS_DIV_MIN)
                && avs_writedata[15:0] <= 16'(AOPS_DIV_MAX))
                div_r <= avs_writedata[15:0];
            if (wr_len)
                len_r <= avs_writedata[AW:0];
            if (wr_stop)
                stopcnt_r <= avs_writedata;
            if (push)
                wp_r <= (wp_r + 1'b1 == (AW+1)'(DEPTH)) ? '0 : wp_r + 1'b1;
            else if (c_rearm)
                wp_r <= '0;
            lvl_r <= c_rearm ? '0 : lvl_r + (push ? 1'b1 : 1'b0) - pop_n;
            // set wins over clear
            if (play && !have && !wrap_one_buffer_flag)
                err_r <= 1'b1;
            else if (c_clrerr)
                err_r <= 1'b0;
        end
    end
    // sequencer
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_r   <= AOPS_IDLE;
            dly_r  <= 6'h00;
            left_r <= 32'h0000_0000;
            rp_r   <= '0;
            ch_r   <= 1'b0;
        end
        else
        begin
            case (st_r)
                AOPS_IDLE:
                    if (trig)
                    begin
                        st_r  <= AOPS_SETTL;
                        dly_r <= 6'h00;
                    end
                AOPS_SETTL:
                    if (c_abort)
                        st_r <= AOPS_DONE;
                    else if (tick)
                    begin
                        dly_r <= dly_r + 6'h01;
                        if (dly_r == 6'(AOPS_GRP_DELAY - 1))
                            st_r <= AOPS_RUN;
                    end
                AOPS_RUN, AOPS_DRAIN:
                    if (c_abort)
                        st_r <= AOPS_DONE;
                    else if (c_order && st_r == AOPS_RUN)
                    begin
                        st_r   <= AOPS_DRAIN;
                        left_r <= stopcnt_r;
                    end
                    else if (play && !take)
                        st_r <= AOPS_DONE;
                    else if (take && st_r == AOPS_DRAIN)
                    begin
                        left_r <= left_r - 32'h0000_0001;
                        if (left_r <= 32'h0000_0001)
                            st_r <= AOPS_DONE;
                    end
                AOPS_DONE:
                    if (c_rearm)
                        st_r <= AOPS_IDLE;
                default:
                    st_r <= AOPS_IDLE;
            endcase
            if (c_rearm)
                rp_r <= '0;
            else if (take)
                rp_r <= rp_inc;
        end
    end
    // outputs; muted playback still advances the pointer
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cur0_r    <= AOPS_MID;
            cur1_r    <= AOPS_MID;
            ramp_r    <= 11'h000;
            dac0_data <= AOPS_MID;
            dac1_data <= AOPS_MID;
            dac_strobe <= 1'b0;
            underrun_evt <= 1'b0;
            led_amber <= 1'b0;
            led_cnt_r <= 16'h0000;
            avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            dac_strobe   <= 1'b0;
            underrun_evt <= play && !have && !wrap_one_buffer_flag;
            if (c_sval && st_r != AOPS_RUN && st_r != AOPS_DRAIN)
            begin
                dac_strobe <= 1'b1;
                if (ctrl_r[AOPS_CTRL_SCH] && CHANNELS == 2)
                    dac1_data <= avs_writedata;
                else
                    dac0_data <= avs_writedata;
            end
            else if (take)
            begin
                cur0_r <= smp0;
                cur1_r <= two_ch ? smp1 : cur1_r;
                ramp_r <= muted ? (ramp_r < 11'(AOPS_MUTE_STEPS)
                        ? ramp_r + 11'h001 : ramp_r)
                        : 11'h000;
                dac0_data  <= scale(smp0, ramp_r);
                dac1_data  <= two_ch ? scale(smp1, ramp_r) : dac1_data;
                dac_strobe <= 1'b1;
            end
            // amber blink in the run state of continuous mode, off while an orderly stop drains
            if (st_r == AOPS_RUN && !wrap_one_buffer_flag)
            begin
                led_cnt_r <= (led_cnt_r == 16'(LED_HALF - 1)) ? 16'h0000
                           : led_cnt_r + 16'h0001;
                if (led_cnt_r == 16'(LED_HALF - 1))
                    led_amber <= !led_amber;
            end
            else
            begin
                led_cnt_r <= 16'h0000;
                led_amber <= 1'b0;
            end
            if (avs_read && !ack_r)
                avs_readdata <= (avs_address == AOPS_REG_STATUS)
                    ? {16'h0000, 11'(lvl_r), st_r}
                    : (avs_address == AOPS_REG_CTRL) ? ctrl_r
                    : (avs_address == AOPS_REG_DIV) ? {16'h0000, div_r}
                    : (avs_address == AOPS_REG_STOPCNT) ? stopcnt_r
                    : {31'h0000_0000, err_r};
        end
    end
    assign avs_waitrequest = !ack_r;
    // assertions
    property p_underrun_pulse;
        @(posedge clk) disable iff (sys_rst)
        (play && !have && !wrap_one_buffer_flag) |=> underrun_evt;
    endproperty
    a_underrun_pulse: assert property (p_underrun_pulse)
        else $error("underrun not reported");
    property p_abort;
        @(posedge clk) disable iff (sys_rst)
        (c_abort && active) |=> st_r == AOPS_DONE;
    endproperty
    a_abort: assert property (p_abort)
        else $error("abort did not halt");
    property p_done_ignores;
        @(posedge clk) disable iff (sys_rst)
        (st_r == AOPS_DONE && trig && !c_rearm) |=> st_r == AOPS_DONE;
    endproperty
    a_done_ignores: assert property (p_done_ignores)
        else $error("trigger after stop");
    property p_settle;
        @(posedge clk) disable iff (sys_rst)
        st_r == AOPS_SETTL |-> !dac_strobe || $past(c_sval);
    endproperty
    a_settle: assert property (p_settle)
        else $error("output during group delay");
    property p_slave;
        @(posedge clk) disable iff (sys_rst)
        (st_r == AOPS_IDLE && slave && !sync_hit) |=> st_r == AOPS_IDLE;
    endproperty
    a_slave: assert property (p_slave)
        else $error("slave started without sync");
    property p_sval;
        @(posedge clk) disable iff (sys_rst)
        (c_sval && st_r == AOPS_IDLE) |=> dac_strobe;
    endproperty
    a_sval: assert property (p_sval)
        else $error("single value not applied");
    property p_wrap;
        @(posedge clk) disable iff (sys_rst)
        (take && wrap_one_buffer_flag && rp_a >= len_r && !c_rearm)
        |=> rp_r == '0;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("waveform did not wrap");
    property p_empty_end;
        @(posedge clk) disable iff (sys_rst)
        (st_r == AOPS_RUN && play && !take && !c_abort && !c_order)
        |=> st_r == AOPS_DONE;
    endproperty
    a_empty_end: assert property (p_empty_end)
        else $error("no end on empty queue");
    c_run: cover property (@(posedge clk) st_r == AOPS_RUN);
    c_drain: cover property (@(posedge clk) st_r == AOPS_DRAIN);
    c_mute: cover property (@(posedge clk)
        ramp_r == 11'(AOPS_MUTE_STEPS));
endmodule
`default_nettype wire

/* design/aops_pkg.sv */
`default_nettype none
package aops_pkg;
    // register byte offsets
    localparam logic [7:0] AOPS_REG_CTRL    = 8'h00;
    localparam logic [7:0] AOPS_REG_CMD     = 8'h04;
    localparam logic [7:0] AOPS_REG_DIV     = 8'h08;
    localparam logic [7:0] AOPS_REG_LEN     = 8'h0C;
    localparam logic [7:0] AOPS_REG_STOPCNT = 8'h10;
    localparam logic [7:0] AOPS_REG_SVAL    = 8'h14;
    localparam logic [7:0] AOPS_REG_FIFO    = 8'h18;
    localparam logic [7:0] AOPS_REG_STATUS  = 8'h1C;
    // ctrl field positions
    localparam int AOPS_CTRL_WRAP  = 0;
    localparam int AOPS_CTRL_TWO   = 1;
    localparam int AOPS_CTRL_TSRC  = 2;
    localparam int AOPS_CTRL_TNEG  = 3;
    localparam int AOPS_CTRL_SLAVE = 4;
    localparam int AOPS_CTRL_MUTE  = 5;
    localparam int AOPS_CTRL_SCH   = 6;
    localparam int AOPS_CTRL_LAST  = 7;
    // command bit positions
    localparam int AOPS_CMD_START  = 0;
    localparam int AOPS_CMD_ORDER  = 1;
    localparam int AOPS_CMD_ABORT  = 2;
    localparam int AOPS_CMD_SVAL   = 3;
    localparam int AOPS_CMD_CLRERR = 4;
    localparam int AOPS_CMD_REARM  = 5;
    // reset values
    localparam logic [31:0] AOPS_CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] AOPS_DIV_RST  = 16'h00E0;
    localparam logic [31:0] AOPS_MID      = 32'h8000_0000;
    // timing figures
    localparam int AOPS_CLK_MHZ     = 200;
    localparam int AOPS_REF_MHZ     = 48;
    localparam int AOPS_XTAL_MHZ    = 24;
    localparam int AOPS_REF_MUL     = AOPS_REF_MHZ / AOPS_XTAL_MHZ;
    localparam int AOPS_REF_DIV     = 4;
    localparam int AOPS_FS_MIN_KHZ  = 30;
    localparam int AOPS_FS_MAX_KHZ  = 216;
    localparam int AOPS_DIV_MIN     =
        (AOPS_REF_MHZ * 1000 + AOPS_FS_MAX_KHZ - 1) / AOPS_FS_MAX_KHZ;
    localparam int AOPS_DIV_MAX     = AOPS_REF_MHZ * 1000 / AOPS_FS_MIN_KHZ;
    localparam int AOPS_GRP_DELAY   = 36;
    localparam int AOPS_MUTE_STEPS  = 1020;
    localparam int AOPS_FIFO_DEPTH  = 8192;
    localparam int AOPS_LED_HALF    = 8192;
    typedef enum logic [4:0] {
        AOPS_IDLE  = 5'b00001,
        AOPS_SETTL = 5'b00010,
        AOPS_RUN   = 5'b00100,
        AOPS_DRAIN = 5'b01000,
        AOPS_DONE  = 5'b10000
    } aops_state_t;
endpackage
`default_nettype wire

/* design/aops_pace_if.sv */
`default_nettype none
interface aops_pace_if;
    logic        run;
    logic [15:0] div;
    logic        tick;
    modport gen (input run, input div, output tick);
    modport use_ (output run, output div, input tick);
endinterface
`default_nettype wire

/* design/aops_pacer.sv */
`default_nettype none
// ref tick is the 48 MHz reference made from 200 MHz by fractional step
module aops_pacer
    import aops_pkg::*;
(
    input  wire logic clk,
    input  wire logic sys_rst,
    aops_pace_if.gen  pi
);
    logic [7:0]  acc_r;
    logic [15:0] cnt_r;
    logic        tick_r;
    wire  [8:0]  acc_sum  = {1'b0, acc_r} + 9'(AOPS_REF_MHZ);
    wire         ref_tick = acc_sum >= 9'(AOPS_CLK_MHZ);
    wire  [7:0]  acc_nxt  = ref_tick ? 8'(acc_sum - 9'(AOPS_CLK_MHZ))
                                     : acc_sum[7:0];
    wire         wrap     = ref_tick && (cnt_r + 16'h0001 >= pi.div);
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            acc_r  <= 8'h00;
            cnt_r  <= 16'h0000;
            tick_r <= 1'b0;
        end
        else
        begin
            acc_r  <= acc_nxt;
            cnt_r  <= !pi.run ? 16'h0000 : wrap ? 16'h0000
                    : ref_tick ? cnt_r + 16'h0001 : cnt_r;
            tick_r <= pi.run && wrap;
        end
    end
    assign pi.tick = tick_r;
    property p_tick_needs_run;
        @(posedge clk) disable iff (sys_rst)
        tick_r |-> $past(pi.run);
    endproperty
    a_tick_needs_run: assert property (p_tick_needs_run)
        else $error("pace tick without run");
endmodule
`default_nettype wire

/* design/aops_edge.sv */
`default_nettype none
// two-flop synchroniser then edge select on the second and third flop
module aops_edge (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic pin,
    input  wire logic neg,
    output logic      hit
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end
        else
        begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    assign hit = neg ? (s3_r && !s2_r) : (!s3_r && s2_r);
endmodule
`default_nettype wire

/* tb/aops_host_model.sv */
`default_nettype none
// host side of the register bus: one access at a time, held until acked
module aops_host_model
    import aops_pkg::*;
(
    // clock
    input  wire logic        clk,
    // avalon-mm master
    output logic [7:0]       avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic [31:0]      avs_writedata,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        avs_address   = 8'h00;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 32'h0000_0000;
    end
    // leading edge keeps two accesses from touching a strobe in one step
    task automatic xfer(input logic rd, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= rd;
        avs_write     <= !rd;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read      <= 1'b0;
        avs_write     <= 1'b0;
        // released lines show junk, not the old value
        avs_address   <= ~a;
        avs_writedata <= ~d;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b0, a, d, q);
    endtask
    // whole pattern before start, ch0 then ch1, offset binary words
    task automatic load(input logic [31:0] s[$]);
        foreach (s[i]) wr(AOPS_REG_FIFO, s[i]);
    endtask
endmodule
`default_nettype wire

/* tb/aops_seq_tb.sv */
`default_nettype none
`define CHK(got, exp, msg) \
    begin check_count++; if ((got) !== (exp)) begin fail_count++; \
    $display("BAD %0t %s", $time, msg); end end
module aops_seq_tb;
    import aops_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 90000;
    logic        clk, sys_rst, ext_trig, sync_clk, sync_trig, common_start;
    logic [7:0]  avs_address;
    logic        avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, dac0_data, dac1_data, rq;
    logic        dac_strobe, underrun_evt, led_amber;
    int          fail_count, check_count, cycles, ticks, first_tick, n;
    int          led_seen, urun_seen;
    logic [31:0] q0[$];
    logic [31:0] q1[$];
    aops_seq #(.CHANNELS(2), .DEPTH(16), .LED_HALF(4)) i_dut (
        .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ext_trig(ext_trig),
        .sync_clk(sync_clk), .sync_trig(sync_trig),
        .common_start(common_start), .dac0_data(dac0_data),
        .dac1_data(dac1_data), .dac_strobe(dac_strobe),
        .underrun_evt(underrun_evt), .led_amber(led_amber));
    aops_host_model i_host (
        .clk(clk), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (led_amber === 1'b1) led_seen++;
        if (underrun_evt === 1'b1) urun_seen++;
        if (dac_strobe === 1'b1)
        begin
            q0.push_back(dac0_data);
            q1.push_back(dac1_data);
            if (first_tick < 0) first_tick = ticks;
        end
        if (cycles >= LIMIT)
        begin
            fail_count++;
            $display("BAD %0t timeout", $time);
            conclude();
        end
    end
    // slave sample clock, only while a test asks for ticks
    task automatic tick(input int k);
        repeat (k)
        begin
            sync_clk <= 1'b1;
            ticks++;
            repeat (4) @(posedge clk);
            sync_clk <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
    task automatic t_reset();
        `CHK(dac0_data, AOPS_MID, "mid code after reset")
        i_host.xfer(1'b1, AOPS_REG_STATUS, 32'h0000_0000, rq);
        `CHK(rq[4:0], AOPS_IDLE, "idle after reset")
        i_host.xfer(1'b1, 8'h40, 32'h0000_0000, rq);
        `CHK(rq, 32'h0000_0000, "unmapped read")
        $display("test reset done");
    endtask
    task automatic t_single();
        i_host.wr(AOPS_REG_CTRL, 32'h0000_0000);
        i_host.wr(AOPS_REG_CMD, 32'hA5A5_0008);
        for (int i = 0; i < 20 && dac0_data !== 32'hA5A5_0008; i++)
            @(posedge clk);
        `CHK(dac0_data, 32'hA5A5_0008, "single value ch0")
        i_host.wr(AOPS_REG_CTRL, 32'h0000_0040);
        i_host.wr(AOPS_REG_CMD, 32'h5A5A_0008);
        for (int i = 0; i < 20 && dac1_data !== 32'h5A5A_0008; i++)
            @(posedge clk);
        `CHK(dac1_data, 32'h5A5A_0008, "single value ch1")
        `CHK(dac0_data, 32'hA5A5_0008, "ch0 kept")
        $display("test single done");
    endtask
    task automatic t_wave();
        i_host.wr(AOPS_REG_CMD, 32'h0000_0020);
        i_host.wr(AOPS_REG_CTRL, 32'h0000_0001);
        i_host.wr(AOPS_REG_DIV, 32'h0000_00DF);
        i_host.wr(AOPS_REG_LEN, 32'h0000_0002);
        i_host.load('{32'h0000_0000, 32'hFFFF_FFFF});
        q0.delete();
        i_host.wr(AOPS_REG_CMD, 32'h0000_0001);
        while (q0.size() < 5) @(posedge clk);
        for (int i = 0; i < 5; i++)
            `CHK(q0[i], (i % 2) ? 32'hFFFF_FFFF : 32'h0, "wrap")
        i_host.wr(AOPS_REG_CMD, 32'h0000_0004);
        @(posedge clk);
        n = q0.size();
        repeat (3000) @(posedge clk);
        `CHK(q0.size(), n, "abort halts")
        i_host.wr(AOPS_REG_CMD, 32'h0000_0001);
        repeat (3000) @(posedge clk);
        `CHK(q0.size(), n, "start ignored after abort")
        $display("test wave done");
    endtask
    task automatic t_slave();
        i_host.wr(AOPS_REG_CMD, 32'h0000_0020);
        i_host.wr(AOPS_REG_CTRL, 32'h0000_0016);
        i_host.load('{32'h1000_0000, 32'h2000_0000,
                      32'h3000_0000, 32'h4000_0000});
        q0.delete();
        q1.delete();
        ext_trig <= 1'b1;
        tick(40);
        `CHK(q0.size(), 0, "pin ignored in slave")
        sync_trig <= 1'b1;
        repeat (4) @(posedge clk);
        sync_trig <= 1'b0;
        ticks = 0;
        first_tick = -1;
        led_seen = 0;
        urun_seen = 0;
        tick(44);
        `CHK(urun_seen, 1, "underrun reported")
        `CHK(led_seen > 0, 1'b1, "led blinks while streaming")
        `CHK(first_tick >= 36, 1'b1, "group delay")
        `CHK(q0.size(), 2, "ends when data runs out")
        `CHK(q0[0], 32'h1000_0000, "instant 0 ch0")
        `CHK(q1[0], 32'h2000_0000, "instant 0 ch1")
        `CHK(q0[1], 32'h3000_0000, "instant 1 ch0")
        `CHK(q1[1], 32'h4000_0000, "instant 1 ch1")
        $display("test slave done");
    endtask
    task automatic t_stop();
        i_host.wr(AOPS_REG_CMD, 32'h0000_0020);
        i_host.wr(AOPS_REG_CTRL, 32'h0000_0012);
        i_host.wr(AOPS_REG_STOPCNT, 32'h0000_0002);
        i_host.load('{32'h0100_0000, 32'h0200_0000, 32'h0300_0000,
                      32'h0400_0000, 32'h0500_0000, 32'h0600_0000,
                      32'h0700_0000, 32'h0800_0000});
        q0.delete();
        urun_seen = 0;
        common_start <= 1'b1;
        @(posedge clk);
        common_start <= 1'b0;
        tick(2);
        i_host.xfer(1'b1, AOPS_REG_STATUS, 32'h0000_0000, rq);
        `CHK(rq[4:0], AOPS_IDLE, "joint start ignored in slave")
        sync_trig <= 1'b1;
        repeat (4) @(posedge clk);
        sync_trig <= 1'b0;
        tick(37);
        i_host.wr(AOPS_REG_CMD, 32'h0000_0002);
        tick(4);
        `CHK(q0.size(), 3, "orderly stop count")
        `CHK(q0[2], 32'h0500_0000, "last ordered sample")
        sync_trig <= 1'b1;
        repeat (4) @(posedge clk);
        sync_trig <= 1'b0;
        tick(40);
        `CHK(q0.size(), 3, "trigger ignored after stop")
        `CHK(urun_seen, 0, "no underrun on orderly stop")
        $display("test stop done");
    endtask
    initial
    begin
        sys_rst = 1'b1;
        ext_trig = 1'b0;
        sync_clk = 1'b0;
        sync_trig = 1'b0;
        common_start = 1'b0;
        first_tick = -1;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_single();
        t_wave();
        t_slave();
        t_stop();
        conclude();
    end
endmodule
`default_nettype wire
